// *** dlf_consts.vh ***
// Constants for the loop filter configuration register bank.
// Assumes inclusion by dlf_cfg_regs.v and by the bench; definitions only.
`ifndef DLF_CONSTS_VH
`define DLF_CONSTS_VH

// Register byte offsets.
`define DLF_OFS_DECIM     4'h0
`define DLF_OFS_TRIM      4'h4
`define DLF_OFS_HOLD      4'h8
`define DLF_OFS_BW        4'hC
`define DLF_OFS_DAMP      8'h10
`define DLF_OFS_CTRL      8'h14
`define DLF_OFS_STAT      8'h18

// Write masks for implemented bits.
`define DLF_MSK_DECIM     32'h0000007F
`define DLF_MSK_TRIM      32'h000000FF
`define DLF_MSK_HOLD      32'h0000FFFF
`define DLF_MSK_BW        32'h0000FFFF
`define DLF_MSK_DAMP      32'h00003F3F
`define DLF_MSK_CTRL      32'h00000007

// Reset values.
`define DLF_RST_DECIM     32'h00000036
`define DLF_RST_TRIM      32'h00000000
`define DLF_RST_HOLD      32'h00003800
`define DLF_RST_BW        32'h00007058
`define DLF_RST_DAMP      32'h00002901
`define DLF_RST_CTRL      32'h00000002

// Holdover shift saturation limit.
`define DLF_HOLD_MAX      5'h14

// Bus responses.
`define DLF_RESP_OKAY     2'h0
`define DLF_RESP_SLVERR   2'h2

`endif

// *** dlf_cfg_regs.v ***
// Loop filter configuration register bank with AXI4-Lite slave.
// Assumes a single 40 MHz clock; lock state and loss-of-lock count
// come from loop logic on the same clock.
//
// Overview of operation
// - 3-bit shift sets switch decimator bandwidth.
// - Switch decimator setting ignored when hitless off.
// - 4-bit main decimator shift; zero passes through.
// - Trim is signed 8-bit, 2^-20 per step.
// - Trim applied as fractional frequency offset.
// - Holdover shift saturates above 20 to 20.
// - Holdover shift zero bypasses holdover filter.
// - Holdover factor zero bypasses holdover filter.
// - Limit flag while loss count exceeds threshold.
// - Acquire bandwidth exponent, reset 0xE.
// - Acquire bandwidth factor, reset zero.
// - Normal bandwidth exponent, reset 0xB.
// - Normal bandwidth factor, reset zero.
// - Acquire damping shift, reset 0x5.
// - Acquire damping factor, reset one.
// - Normal damping shift, reset zero.
// - Normal damping factor, reset one.
// - Auto switch picks acquire settings in acquire.
// - Hitless enable gates switch decimator setting.
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`include "dlf_consts.vh"

module dlf_cfg_regs #(
  parameter LOL_CNT_W = 4
) (
  input  wire                 clk_i,
  input  wire                 rst_i,
  input  wire [5:0]           s_axi_awaddr_i,
  input  wire                 s_axi_awvalid_i,
  output reg                  s_axi_awready_o,
  input  wire [31:0]          s_axi_wdata_i,
  input  wire [3:0]           s_axi_wstrb_i,
  input  wire                 s_axi_wvalid_i,
  output reg                  s_axi_wready_o,
  output reg  [1:0]           s_axi_bresp_o,
  output reg                  s_axi_bvalid_o,
  input  wire                 s_axi_bready_i,
  input  wire [5:0]           s_axi_araddr_i,
  input  wire                 s_axi_arvalid_i,
  output reg                  s_axi_arready_o,
  output reg  [31:0]          s_axi_rdata_o,
  output reg  [1:0]           s_axi_rresp_o,
  output reg                  s_axi_rvalid_o,
  input  wire                 s_axi_rready_i,
  input  wire                 acquire_state_i,
  input  wire [LOL_CNT_W-1:0] lock_loss_count_i,
  output reg                  lock_loss_limit_o,
  output reg  [3:0]           main_decimator_bw_exponent_o,
  output reg  [2:0]           switch_decimator_bw_exponent_o,
  output reg                  switch_decimator_active_o,
  output reg  [31:0]          trim_frac_offset_o,
  output reg  [4:0]           hold_filter_bw_exponent_o,
  output reg  [2:0]           hold_filter_bw_factor_o,
  output reg                  hold_filter_bypass_o,
  output reg  [3:0]           hold_history_o,
  output reg  [4:0]           loop_bw_exponent_o,
  output reg  [2:0]           loop_bw_factor_o,
  output reg  [2:0]           loop_damp_shift_o,
  output reg  [2:0]           loop_damp_factor_o,
  output reg                  filter_update_hold_o
);

  localparam [31:0] RST_DECIM = `DLF_RST_DECIM;
  localparam [31:0] RST_TRIM  = `DLF_RST_TRIM;
  localparam [31:0] RST_HOLD  = `DLF_RST_HOLD;
  localparam [31:0] RST_BW    = `DLF_RST_BW;
  localparam [31:0] RST_DAMP  = `DLF_RST_DAMP;
  localparam [31:0] RST_CTRL  = `DLF_RST_CTRL;

  reg  [31:0] decim_r;
  reg  [31:0] trim_r;
  reg  [31:0] hold_r;
  reg  [31:0] bw_r;
  reg  [31:0] damp_r;
  reg  [31:0] ctrl_r;
  reg  [31:0] decim_nxt;
  reg  [31:0] trim_nxt;
  reg  [31:0] hold_nxt;
  reg  [31:0] bw_nxt;
  reg  [31:0] damp_nxt;
  reg  [31:0] ctrl_nxt;
  reg  [5:0]  awaddr_r;
  reg         aw_held_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg         w_held_r;
  reg  [31:0] rdata_nxt;
  reg         rd_hit_nxt;
  reg  [4:0]  hold_exp_nxt;
  reg         use_acq;
  wire        do_write;
  wire [31:0] strb_mask;
  wire [7:0]  wr_off;
  wire [7:0]  rd_off;
  wire        wr_hit;
  wire        we_decim;
  wire        we_trim;
  wire        we_hold;
  wire        we_bw;
  wire        we_damp;
  wire        we_ctrl;

  // Register fields as seen by the loop filter datapath.
  wire [3:0]  main_exp_f    = decim_r[3:0];
  wire [2:0]  switch_exp_f  = decim_r[6:4];
  wire [7:0]  trim_f        = trim_r[7:0];
  wire [2:0]  hold_fac_f    = hold_r[10:8];
  wire [3:0]  hold_hist_f   = hold_r[7:4];
  wire [3:0]  loss_lim_f    = hold_r[3:0];
  wire [4:0]  acq_bw_exp_f  = bw_r[15:11];
  wire [2:0]  acq_bw_fac_f  = bw_r[10:8];
  wire [4:0]  nrm_bw_exp_f  = bw_r[7:3];
  wire [2:0]  nrm_bw_fac_f  = bw_r[2:0];
  wire [2:0]  acq_dmp_sh_f  = damp_r[13:11];
  wire [2:0]  acq_dmp_fac_f = damp_r[10:8];
  wire [2:0]  nrm_dmp_sh_f  = damp_r[5:3];
  wire [2:0]  nrm_dmp_fac_f = damp_r[2:0];
  wire        hitless_en_f  = ctrl_r[0];
  wire        freeze_f      = ctrl_r[2];

  assign strb_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign do_write  = aw_held_r & w_held_r & ~s_axi_bvalid_o;
  assign wr_off    = {2'h0, awaddr_r[5:2], 2'h0};
  assign rd_off    = {2'h0, s_axi_araddr_i[5:2], 2'h0};
  assign wr_hit    = (wr_off == {4'h0, `DLF_OFS_DECIM}) | (wr_off == {4'h0, `DLF_OFS_TRIM})
                   | (wr_off == {4'h0, `DLF_OFS_HOLD}) | (wr_off == {4'h0, `DLF_OFS_BW})
                   | (wr_off == `DLF_OFS_DAMP) | (wr_off == `DLF_OFS_CTRL);

  // Per-register write enables.
  assign we_decim = do_write & (wr_off == {4'h0, `DLF_OFS_DECIM});
  assign we_trim  = do_write & (wr_off == {4'h0, `DLF_OFS_TRIM});
  assign we_hold  = do_write & (wr_off == {4'h0, `DLF_OFS_HOLD});
  assign we_bw    = do_write & (wr_off == {4'h0, `DLF_OFS_BW});
  assign we_damp  = do_write & (wr_off == `DLF_OFS_DAMP);
  assign we_ctrl  = do_write & (wr_off == `DLF_OFS_CTRL);

  // Write address is caught on its own handshake.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b0;
      aw_held_r       <= 1'b0;
      awaddr_r        <= 6'h00;
    end else begin
      s_axi_awready_o <= ~aw_held_r & ~s_axi_awready_o & s_axi_awvalid_i;
      if (s_axi_awvalid_i & s_axi_awready_o) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr_i;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  // Write data is caught on its own handshake, in either order.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_wready_o <= 1'b0;
      w_held_r       <= 1'b0;
      wdata_r        <= 32'h00000000;
      wstrb_r        <= 4'h0;
    end else begin
      s_axi_wready_o <= ~w_held_r & ~s_axi_wready_o & s_axi_wvalid_i;
      if (s_axi_wvalid_i & s_axi_wready_o) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata_i;
        wstrb_r  <= s_axi_wstrb_i;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Write response follows once both halves are held.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `DLF_RESP_OKAY;
    end else begin
      if (do_write) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_hit ? `DLF_RESP_OKAY : `DLF_RESP_SLVERR;
      end else if (s_axi_bvalid_o & s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // Next register values merge the strobed bytes.
  always @* begin
    decim_nxt = decim_r;
    trim_nxt  = trim_r;
    hold_nxt  = hold_r;
    bw_nxt    = bw_r;
    damp_nxt  = damp_r;
    ctrl_nxt  = ctrl_r;
    if (we_decim)
      decim_nxt = (decim_r & ~strb_mask) | (wdata_r & strb_mask & `DLF_MSK_DECIM);
    if (we_trim)
      trim_nxt = (trim_r & ~strb_mask) | (wdata_r & strb_mask & `DLF_MSK_TRIM);
    if (we_hold)
      hold_nxt = (hold_r & ~strb_mask) | (wdata_r & strb_mask & `DLF_MSK_HOLD);
    if (we_bw)
      bw_nxt = (bw_r & ~strb_mask) | (wdata_r & strb_mask & `DLF_MSK_BW);
    if (we_damp)
      damp_nxt = (damp_r & ~strb_mask) | (wdata_r & strb_mask & `DLF_MSK_DAMP);
    if (we_ctrl)
      ctrl_nxt = (ctrl_r & ~strb_mask) | (wdata_r & strb_mask & `DLF_MSK_CTRL);
  end

  // Register storage.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      decim_r <= `DLF_RST_DECIM;
      trim_r  <= `DLF_RST_TRIM;
      hold_r  <= `DLF_RST_HOLD;
      bw_r    <= `DLF_RST_BW;
      damp_r  <= `DLF_RST_DAMP;
      ctrl_r  <= `DLF_RST_CTRL;
    end else begin
      decim_r <= decim_nxt;
      trim_r  <= trim_nxt;
      hold_r  <= hold_nxt;
      bw_r    <= bw_nxt;
      damp_r  <= damp_nxt;
      ctrl_r  <= ctrl_nxt;
    end
  end

  // Read decode; status shows the live lock-loss flag and profile.
  always @* begin
    rdata_nxt  = 32'h00000000;
    rd_hit_nxt = 1'b1;
    case (rd_off)
      {4'h0, `DLF_OFS_DECIM}: rdata_nxt = decim_r;
      {4'h0, `DLF_OFS_TRIM}:  rdata_nxt = trim_r;
      {4'h0, `DLF_OFS_HOLD}:  rdata_nxt = hold_r;
      {4'h0, `DLF_OFS_BW}:    rdata_nxt = bw_r;
      `DLF_OFS_DAMP:          rdata_nxt = damp_r;
      `DLF_OFS_CTRL:          rdata_nxt = ctrl_r;
      `DLF_OFS_STAT:          rdata_nxt = {30'h00000000, use_acq, lock_loss_limit_o};
      default:                rd_hit_nxt = 1'b0;
    endcase
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h00000000;
      s_axi_rresp_o   <= `DLF_RESP_OKAY;
    end else begin
      s_axi_arready_o <= ~s_axi_rvalid_o & ~s_axi_arready_o & s_axi_arvalid_i;
      if (s_axi_arvalid_i & s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o  <= rdata_nxt;
        s_axi_rresp_o  <= rd_hit_nxt ? `DLF_RESP_OKAY : `DLF_RESP_SLVERR;
      end else if (s_axi_rvalid_o & s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // Profile select and holdover saturation.
  always @* begin
    use_acq = ctrl_r[1] & acquire_state_i;
    if (hold_r[15:11] > `DLF_HOLD_MAX)
      hold_exp_nxt = `DLF_HOLD_MAX;
    else
      hold_exp_nxt = hold_r[15:11];
  end

  // Lock-loss limit flag.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_loss_limit_o <= 1'b0;
    end else begin
      lock_loss_limit_o <= ({{(32-LOL_CNT_W){1'b0}}, lock_loss_count_i} > {28'h0000000, loss_lim_f});
    end
  end

  // Decimator settings.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      main_decimator_bw_exponent_o   <= RST_DECIM[3:0];
      switch_decimator_bw_exponent_o <= RST_DECIM[6:4];
      switch_decimator_active_o      <= RST_CTRL[0];
    end else begin
      main_decimator_bw_exponent_o <= main_exp_f;
      switch_decimator_bw_exponent_o <= switch_exp_f;
      switch_decimator_active_o <= hitless_en_f;
    end
  end

  // Crystal trim offset.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trim_frac_offset_o <= {{24{RST_TRIM[7]}}, RST_TRIM[7:0]};
    end else begin
      trim_frac_offset_o <= {{24{trim_f[7]}}, trim_f};
    end
  end

  // Holdover filter settings.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_filter_bw_exponent_o <= RST_HOLD[15:11];
      hold_filter_bw_factor_o   <= RST_HOLD[10:8];
      hold_filter_bypass_o      <= 1'b1;
      hold_history_o            <= RST_HOLD[7:4];
    end else begin
      hold_filter_bw_exponent_o <= hold_exp_nxt;
      hold_filter_bw_factor_o <= hold_fac_f;
      hold_filter_bypass_o <= (hold_exp_nxt == 5'h00) | (hold_fac_f == 3'h0);
      hold_history_o       <= hold_hist_f;
    end
  end

  // Filter update freeze.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      filter_update_hold_o <= RST_CTRL[2];
    end else begin
      filter_update_hold_o <= freeze_f;
    end
  end

  // Selected loop profile.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      loop_bw_exponent_o <= RST_BW[7:3];
      loop_bw_factor_o   <= RST_BW[2:0];
      loop_damp_shift_o  <= RST_DAMP[5:3];
      loop_damp_factor_o <= RST_DAMP[2:0];
    end else if (use_acq) begin
      loop_bw_exponent_o <= acq_bw_exp_f;
      loop_bw_factor_o   <= acq_bw_fac_f;
      loop_damp_shift_o  <= acq_dmp_sh_f;
      loop_damp_factor_o <= acq_dmp_fac_f;
    end else begin
      loop_bw_exponent_o <= nrm_bw_exp_f;
      loop_bw_factor_o   <= nrm_bw_fac_f;
      loop_damp_shift_o  <= nrm_dmp_sh_f;
      loop_damp_factor_o <= nrm_dmp_fac_f;
    end
  end

endmodule

// *** dlf_cfg_regs_chk.sv ***
// Checker for the loop filter register bank outputs and bus handshakes.
// Assumes binding to dlf_cfg_regs on its single clock and async reset.
module dlf_chk #(parameter LOL_CNT_W = 4) (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 s_axi_awready_o,
  input wire logic                 s_axi_bvalid_o,
  input wire logic                 s_axi_bready_i,
  input wire logic [1:0]           s_axi_bresp_o,
  input wire logic                 s_axi_arvalid_i,
  input wire logic                 s_axi_arready_o,
  input wire logic                 s_axi_rvalid_o,
  input wire logic                 s_axi_rready_i,
  input wire logic [31:0]          s_axi_rdata_o,
  input wire logic [LOL_CNT_W-1:0] lock_loss_count_i,
  input wire logic                 lock_loss_limit_o,
  input wire logic [4:0]           hold_filter_bw_exponent_o,
  input wire logic [2:0]           hold_filter_bw_factor_o,
  input wire logic                 hold_filter_bypass_o,
  input wire logic [31:0]          trim_frac_offset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_hold_sat: assert property (hold_filter_bw_exponent_o <= 5'h14)
    else $error("holdover exponent above limit");
  a_hold_bypass: assert property (hold_filter_bypass_o ==
    (hold_filter_bw_exponent_o == 5'h0 || hold_filter_bw_factor_o == 3'h0)) else $error("holdover bypass wrong");
  a_trim_sign: assert property (trim_frac_offset_o[31:8] == {24{trim_frac_offset_o[7]}})
    else $error("trim not sign extended");
  a_limit_zero: assert property (lock_loss_count_i == 0 |=> !lock_loss_limit_o)
    else $error("limit flag with zero count");
  a_aw_pulse: assert property (s_axi_awready_o |=> !s_axi_awready_o) else $error("awready not a pulse");
  a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
endmodule
bind dlf_cfg_regs dlf_chk #(.LOL_CNT_W(LOL_CNT_W)) chk_u (.clk_i, .rst_i, .s_axi_awready_o, .s_axi_bvalid_o,
  .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .s_axi_rdata_o, .lock_loss_count_i, .lock_loss_limit_o, .hold_filter_bw_exponent_o, .hold_filter_bw_factor_o,
  .hold_filter_bypass_o, .trim_frac_offset_o);

// *** dlf_cfg_regs_bench.sv ***
// Self-checking bench for the loop filter register bank.
// Assumes dlf_cfg_regs with a 4-bit loss count and the checker bound to it.
`include "dlf_consts.vh"
module dlf_cfg_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, acquire_state_i = 0;
  logic [5:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
  logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, trim_frac_offset_o, v;
  logic [3:0] s_axi_wstrb_i = 4'hF, lock_loss_count_i = 0, main_decimator_bw_exponent_o, hold_history_o;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, lock_loss_limit_o;
  logic switch_decimator_active_o, hold_filter_bypass_o, filter_update_hold_o, sel;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, br;
  logic [2:0] switch_decimator_bw_exponent_o, hold_filter_bw_factor_o, loop_bw_factor_o;
  logic [2:0] loop_damp_shift_o, loop_damp_factor_o;
  logic [4:0] hold_filter_bw_exponent_o, loop_bw_exponent_o, e;
  logic [33:0] rd_q[$];
  logic [31:0] msk[5] = '{`DLF_MSK_DECIM, `DLF_MSK_TRIM, `DLF_MSK_HOLD, `DLF_MSK_BW, `DLF_MSK_DAMP};
  logic [31:0] tbl[4] = '{32'h0000A580, 32'h0000AF7F, 32'h00000601, 32'h00003855};
  int fails = 0, n_tests = 0, cyc = 0, seed = 15;
  dlf_cfg_regs #(.LOL_CNT_W(4)) dut_u (.clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .acquire_state_i, .lock_loss_count_i,
    .lock_loss_limit_o, .main_decimator_bw_exponent_o, .switch_decimator_bw_exponent_o,
    .switch_decimator_active_o, .trim_frac_offset_o, .hold_filter_bw_exponent_o, .hold_filter_bw_factor_o,
    .hold_filter_bypass_o, .hold_history_o, .loop_bw_exponent_o, .loop_bw_factor_o, .loop_damp_shift_o,
    .loop_damp_factor_o, .filter_update_hold_o);
  initial forever #12.5 clk_i = ~clk_i;
  task chk(input string n, input logic [33:0] x, input logic [33:0] g);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 0;
    dd = 0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    while (!(ad && dd)) begin
      @(posedge clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o === 1'b1) begin ad = 1; s_axi_awvalid_i <= 0; end
      if (s_axi_wvalid_i && s_axi_wready_o === 1'b1) begin dd = 1; s_axi_wvalid_i <= 0; end
    end
    s_axi_bready_i <= 1;
    do @(posedge clk_i); while (s_axi_bvalid_o !== 1'b1);
    br = s_axi_bresp_o;
    s_axi_bready_i <= 0;
  endtask
  task rd(input logic [5:0] a, input logic [33:0] x);
    rd_q.push_back(x);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    do @(posedge clk_i); while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 0;
    s_axi_rready_i <= 1;
    do @(posedge clk_i); while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 0;
  endtask
  task settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  always @(posedge clk_i) begin
    if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i) chk("rdata", rd_q.pop_front(), {s_axi_rresp_o, s_axi_rdata_o});
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      give_verdict;
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(6'h00, {2'h0, `DLF_RST_DECIM});
    rd(6'h04, {2'h0, `DLF_RST_TRIM});
    rd(6'h08, {2'h0, `DLF_RST_HOLD});
    rd(6'h0C, {2'h0, `DLF_RST_BW});
    rd(6'h10, {2'h0, `DLF_RST_DAMP});
    rd(6'h14, {2'h0, `DLF_RST_CTRL});
    chk("decim", {4'h6, 3'h3}, {main_decimator_bw_exponent_o, switch_decimator_bw_exponent_o});
    chk("hold", {5'h7, 1'b1}, {hold_filter_bw_exponent_o, hold_filter_bypass_o});
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wr(i * 4, 32'hFFFFFFFF);
      rd(i * 4, {2'h0, msk[i]});
    end
    settle;
    chk("sat", {5'h14, 3'h7, 1'b0}, {hold_filter_bw_exponent_o, hold_filter_bw_factor_o, hold_filter_bypass_o});
    chk("decim", {4'hF, 3'h7}, {main_decimator_bw_exponent_o, switch_decimator_bw_exponent_o});
    $display("test reserved done");
    for (int i = 0; i < 10; i++) begin
      v = (i < 4) ? tbl[i] : $random(seed);
      wr(6'h04, v);
      wr(6'h08, v);
      lock_loss_count_i <= v[7:4];
      settle;
      e = (v[15:11] > 5'h14) ? 5'h14 : v[15:11];
      chk("trim", {{24{v[7]}}, v[7:0]}, trim_frac_offset_o);
      chk("hexp", e, hold_filter_bw_exponent_o);
      chk("bypass", e == 0 || v[10:8] == 0, hold_filter_bypass_o);
      chk("limit", v[7:4] > v[3:0], lock_loss_limit_o);
      chk("hist", v[7:4], hold_history_o);
    end
    $display("test hold done");
    lock_loss_count_i <= 0;
    wr(6'h14, 32'h00000006);
    wr(6'h0C, 32'h0000A92D);
    wr(6'h10, 32'h0000321C);
    for (int k = 0; k < 8; k++) begin
      wr(6'h14, k);
      acquire_state_i <= k[0] ^ k[2];
      settle;
      sel = k[1] & (k[0] ^ k[2]);
      chk("profile", sel ? 14'h2A72 : 14'h0B5C, {loop_bw_exponent_o, loop_bw_factor_o, loop_damp_shift_o,
        loop_damp_factor_o});
      chk("ctrl", {k[0], k[2]}, {switch_decimator_active_o, filter_update_hold_o});
      rd(6'h18, {2'h0, 30'h0, sel, 1'b0});
    end
    $display("test profile done");
    wr(6'h1C, 32'h12345678);
    chk("bresp", `DLF_RESP_SLVERR, br);
    rd(6'h1C, {`DLF_RESP_SLVERR, 32'h0});
    $display("test unmapped done");
    give_verdict;
  end
endmodule
